/* verilog/codec_pkg.sv */
// constants, register map and word layouts for the codec serial port
// assumes a single 10 MHz system clock standing in for the master clock
// How it works
// - shift clock is driven by the device, derived from its master clock
// - serial port is shift clock, two frame syncs, data out, data in
// - primary words carry samples; secondary words carry control only
// - bit 0 of an incoming primary word set means secondary requested
// - secondary receive sync follows 48 shift clocks after the primary sync
// - every data bit is launched and sampled on the shift clock rise
// - converter output frames run at 1104 or 2208 kHz by mode
// - rate mode from pin, or from register when its select bit is set
// - incoming sample frames run at 276 or 552 kHz by register
// - filter bit 4 picks transmit low-pass corner 138 or 125 kHz
// - filter bit 2 picks receive high-pass corner 180 or 168 kHz
// - transmit attenuation 0 to 24 dB in 1 dB steps from register
// - register bit bypasses the transmit digital high-pass filter
// - register bit powers down the line driver
// - receive fine gain 0 to 9 dB in 1 dB steps from register
// - DAC code is high register then low register bits 3 to 0
// - DAC code loads only on a low register write
// - DAC code is two's complement; level is code plus 2048
// - aux clock one 20.187 or 15.701 MHz by select; two 4.096 MHz
// - each aux clock output can be disabled
// - primary word: bits 15..2 sample, bit 1 ignored, bit 0 request
// - secondary word: bits 14..10 address, 7..0 data, bit 15 zero
// - each frame sync is high one shift clock before a 16-bit word
// - no read-back: no secondary output sync or word ever
package codec_pkg;
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned SCLK_HZ = 35_328_000;
    localparam int unsigned OUT_LITE_HZ = 1_104_000;
    localparam int unsigned OUT_FULL_HZ = 2_208_000;
    localparam int unsigned IN_NORMAL_HZ = 276_000;
    localparam int unsigned IN_DOUBLE_HZ = 552_000;
    localparam int unsigned OUT_LITE_SCLKS = SCLK_HZ / OUT_LITE_HZ;
    localparam int unsigned OUT_FULL_SCLKS = SCLK_HZ / OUT_FULL_HZ;
    localparam int unsigned IN_NORMAL_SCLKS = SCLK_HZ / IN_NORMAL_HZ;
    localparam int unsigned IN_DOUBLE_SCLKS = SCLK_HZ / IN_DOUBLE_HZ;
    localparam int unsigned SEC_DELAY_SCLKS = 48;
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CLK1_FAST_HZ = 20_187_000;
    localparam int unsigned CLK1_SLOW_HZ = 15_701_000;
    localparam int unsigned CLK2_HZ = 4_096_000;
    // half periods in system cycles, rounded down, never below one
    function automatic int unsigned half_cycles(int unsigned hz);
        int unsigned n;
        n = SYS_CLK_HZ / (2 * hz);
        return (n < 1) ? 1 : n;
    endfunction
    localparam int unsigned SCLK_HALF = half_cycles(SCLK_HZ);
    localparam int unsigned CLK1_FAST_HALF = half_cycles(CLK1_FAST_HZ);
    localparam int unsigned CLK1_SLOW_HALF = half_cycles(CLK1_SLOW_HZ);
    localparam int unsigned CLK2_HALF = half_cycles(CLK2_HZ);
    // control register addresses carried in secondary words
    localparam logic [4:0] REG_MODE = 5'h01;
    localparam logic [4:0] REG_FILTER = 5'h02;
    localparam logic [4:0] REG_TX_ATTEN = 5'h03;
    localparam logic [4:0] REG_RX_GAIN = 5'h04;
    localparam logic [4:0] REG_POWER = 5'h05;
    localparam logic [4:0] REG_CLOCK = 5'h06;
    localparam logic [4:0] REG_VC_HIGH = 5'h07;
    localparam logic [4:0] REG_VC_LOW = 5'h08;
    localparam int unsigned MODE_LITE_BIT = 0;
    localparam int unsigned MODE_USE_REG_BIT = 1;
    localparam int unsigned MODE_IN_DOUBLE_BIT = 2;
    localparam int unsigned MODE_HPF_BYPASS_BIT = 3;
    localparam int unsigned FMR_TX_LPF_BIT = 4;
    localparam int unsigned FMR_RX_HPF_BIT = 2;
    localparam int unsigned PWR_DRIVER_BIT = 0;
    localparam int unsigned CLK1_SEL_BIT = 0;
    localparam int unsigned CLK1_EN_BIT = 1;
    localparam int unsigned CLK2_EN_BIT = 2;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] FILTER_RST = 8'h00;
    localparam logic [7:0] POWER_RST = 8'h00;
    localparam logic [7:0] CLOCK_RST = 8'h06;
    localparam logic [7:0] VC_RST = 8'h00;
    localparam logic [4:0] ATTEN_RST = 5'h00;
    localparam logic [3:0] FINE_RST = 4'h0;
    localparam logic [3:0] COARSE_RST = 4'h0;
    localparam logic [4:0] ATTEN_MAX_DB = 5'h18;
    localparam logic [3:0] FINE_MAX_DB = 4'h9;
    localparam logic [11:0] DAC_OFFSET = 12'h800;
    typedef struct packed {
        logic [13:0] sample;
        logic unused;
        logic request;
    } prim_word_s;
    typedef struct packed {
        logic zero;
        logic [4:0] addr;
        logic [1:0] unused;
        logic [7:0] data;
    } sec_word_s;
endpackage

/* verilog/sample_fifo.sv */
// small first-in first-out buffer with valid and ready on both sides
// assumes a single clock and an asynchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 8
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // asynchronous reset
    input wire logic [WIDTH-1:0] in_data, // word to store
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic out_valid, // a word is held
    input wire logic out_ready // oldest word taken
);
    localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("sample_fifo needs a power of two depth of at least 2");
        end
    endgenerate
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/codec_serial_port.sv */
// serial port, control registers, DAC code and aux clocks of the codec
// assumes pins are synchronous to sys_clk; sys_clk stands in for mclk
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port #(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // asynchronous reset, active high
    output logic shift_clock, // serial shift clock to host
    output logic transmit_frame_sync, // sync ahead of each output word
    output logic receive_frame_sync, // sync ahead of each input word
    output logic serial_out_line, // serial data to host
    input wire logic serial_in_line, // serial data from host
    input wire logic rate_mode_pin, // 1 reduced rate, 0 full rate
    input wire logic [13:0] adc_sample, // converter sample to send
    input wire logic adc_valid, // converter sample offered
    output logic adc_ready, // room in the sample buffer
    output logic [13:0] dac_sample, // sample received from host
    output logic dac_valid, // pulse, new sample received
    output logic reduced_rate, // effective rate mode
    output logic tx_lpf_125k, // transmit low-pass at 125 kHz
    output logic rx_hpf_168k, // receive high-pass at 168 kHz
    output logic tx_hpf_bypass, // bypass transmit digital high-pass
    output logic driver_power_down, // line driver powered down
    output logic [4:0] tx_atten_db, // transmit attenuation in dB
    output logic [3:0] rx_fine_gain_db, // receive fine gain in dB
    output logic [3:0] coarse_receive_gain, // coarse gain code
    output logic [11:0] vcxo_dac_code, // two's complement DAC code
    output logic [11:0] vcxo_dac_level, // offset binary DAC level
    output logic aux_clock_one, // auxiliary clock one
    output logic aux_clock_two // auxiliary clock two
);
    generate
        if (FIFO_DEPTH < 2) begin : g_bad
            $error("codec_serial_port needs a sample buffer of 2 or more");
        end
    endgenerate

    // shift clock divider; rise marks the shared launch and sample edge
    logic [7:0] sdiv_q;
    logic sclk_q;
    logic rise;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sdiv_q <= 8'h00;
            sclk_q <= 1'b0;
        end else if (sdiv_q == 8'(codec_pkg::SCLK_HALF - 1)) begin
            sdiv_q <= 8'h00;
            sclk_q <= ~sclk_q;
        end else begin
            sdiv_q <= sdiv_q + 8'h01;
        end
    end
    assign rise = (sdiv_q == 8'(codec_pkg::SCLK_HALF - 1)) && !sclk_q;
    assign shift_clock = sclk_q;

    // frame counter in shift clocks, spans the longest frame
    logic [6:0] fcnt_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fcnt_q <= 7'h00;
        end else if (rise) begin
            fcnt_q <= fcnt_q + 7'h01;
        end
    end

    // control registers
    logic [7:0] mode_q;
    logic [7:0] filter_q;
    logic [7:0] power_q;
    logic [7:0] clock_q;
    logic [7:0] vc_high_q;
    logic [7:0] vc_low_q;
    logic [4:0] atten_q;
    logic [3:0] fine_q;
    logic [3:0] coarse_q;
    logic [11:0] dac_code_q;
    logic in_double;

    assign reduced_rate = mode_q[codec_pkg::MODE_USE_REG_BIT]
        ? mode_q[codec_pkg::MODE_LITE_BIT] : rate_mode_pin;
    assign in_double = mode_q[codec_pkg::MODE_IN_DOUBLE_BIT];

    // frame starts: output word frames and incoming primary frames
    logic out_start;
    logic in_start;
    always_comb begin
        if (reduced_rate) begin
            out_start = (fcnt_q % 7'(codec_pkg::OUT_LITE_SCLKS)) == 7'h00;
        end else begin
            out_start = (fcnt_q % 7'(codec_pkg::OUT_FULL_SCLKS)) == 7'h00;
        end
    end
    always_comb begin
        if (in_double) begin
            in_start = (fcnt_q % 7'(codec_pkg::IN_DOUBLE_SCLKS)) == 7'h00;
        end else begin
            // eight bits: a 128 divisor does not fit the seven-bit count
            in_start = ({1'b0, fcnt_q} % 8'(codec_pkg::IN_NORMAL_SCLKS))
                == 8'h00;
        end
    end

    // sample buffer between the converter and the serial output
    logic [13:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    sample_fifo #(
        .WIDTH(14),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_data(adc_sample),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );
    // samples only go out in primary words
    assign fifo_pop = rise && out_start;

    // output shifter; the lowest two bits stay zero
    logic fsx_q;
    logic sdo_q;
    logic [15:0] out_sr_q;
    logic [4:0] out_left_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fsx_q <= 1'b0;
        end else if (rise) begin
            fsx_q <= out_start;
        end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_sr_q <= 16'h0000;
            out_left_q <= 5'h00;
            sdo_q <= 1'b0;
        end else if (rise) begin
            if (out_start) begin
                out_sr_q <= fifo_valid ? {fifo_data, 2'b00} : 16'h0000;
                out_left_q <= 5'(codec_pkg::WORD_BITS);
                sdo_q <= 1'b0;
            end else if (out_left_q != 5'h00) begin
                sdo_q <= out_sr_q[15];
                out_sr_q <= {out_sr_q[14:0], 1'b0};
                out_left_q <= out_left_q - 5'h01;
            end else begin
                sdo_q <= 1'b0;
            end
        end
    end
    assign transmit_frame_sync = fsx_q;
    assign serial_out_line = sdo_q;

    // input side: primary frame, pending request, secondary frame
    logic fsr_q;
    logic [14:0] in_sr_q;
    logic [4:0] in_left_q;
    logic in_sec_q;
    logic sec_pend_q;
    logic [5:0] since_q;
    logic sec_start;
    logic word_done;
    logic [15:0] word;
    codec_pkg::prim_word_s prim;
    codec_pkg::sec_word_s sec;

    assign sec_start = sec_pend_q
        && since_q == 6'(codec_pkg::SEC_DELAY_SCLKS - 1);
    assign word_done = rise && in_left_q == 5'h01;
    assign word = {in_sr_q, serial_in_line};
    assign prim = codec_pkg::prim_word_s'(word);
    assign sec = codec_pkg::sec_word_s'(word);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fsr_q <= 1'b0;
        end else if (rise) begin
            fsr_q <= in_start || sec_start;
        end
    end
    assign receive_frame_sync = fsr_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            in_sr_q <= 15'h0000;
            in_left_q <= 5'h00;
            in_sec_q <= 1'b0;
        end else if (rise) begin
            if (in_start || sec_start) begin
                in_left_q <= 5'(codec_pkg::WORD_BITS);
                in_sec_q <= sec_start && !in_start;
            end else if (in_left_q != 5'h00) begin
                in_sr_q <= word[14:0];
                in_left_q <= in_left_q - 5'h01;
            end
        end
    end

    // shift clocks since the last primary sync
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            since_q <= 6'h00;
        end else if (rise) begin
            if (in_start) begin
                since_q <= 6'h00;
            end else if (since_q != 6'h3F) begin
                since_q <= since_q + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sec_pend_q <= 1'b0;
        end else if (word_done && !in_sec_q) begin
            sec_pend_q <= prim.request;
        end else if (rise && sec_start) begin
            sec_pend_q <= 1'b0;
        end
    end

    // sample bits 15..2 to the converter
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dac_sample <= 14'h0000;
            dac_valid <= 1'b0;
        end else begin
            dac_valid <= word_done && !in_sec_q;
            if (word_done && !in_sec_q) begin
                dac_sample <= prim.sample;
            end
        end
    end

    // register write from a secondary word
    logic wr_en;
    assign wr_en = word_done && in_sec_q && !sec.zero;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_q <= codec_pkg::MODE_RST;
            filter_q <= codec_pkg::FILTER_RST;
            power_q <= codec_pkg::POWER_RST;
            clock_q <= codec_pkg::CLOCK_RST;
        end else if (wr_en) begin
            unique case (sec.addr)
                codec_pkg::REG_MODE: begin
                    mode_q <= sec.data;
                end
                codec_pkg::REG_FILTER: begin
                    filter_q <= sec.data;
                end
                codec_pkg::REG_POWER: begin
                    power_q <= sec.data;
                end
                codec_pkg::REG_CLOCK: begin
                    clock_q <= sec.data;
                end
                default: begin
                end
            endcase
        end
    end

    // fine gain and attenuation clamp at their top step; coarse gain is not clamped
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            atten_q <= codec_pkg::ATTEN_RST;
            fine_q <= codec_pkg::FINE_RST;
            coarse_q <= codec_pkg::COARSE_RST;
        end else if (wr_en) begin
            if (sec.addr == codec_pkg::REG_TX_ATTEN) begin
                atten_q <= (sec.data > 8'(codec_pkg::ATTEN_MAX_DB))
                    ? codec_pkg::ATTEN_MAX_DB : sec.data[4:0];
            end
            if (sec.addr == codec_pkg::REG_RX_GAIN) begin
                // fine gain 0 to 9 dB
                fine_q <= (sec.data[3:0] > codec_pkg::FINE_MAX_DB)
                    ? codec_pkg::FINE_MAX_DB : sec.data[3:0];
                coarse_q <= sec.data[7:4];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            vc_high_q <= codec_pkg::VC_RST;
            vc_low_q <= codec_pkg::VC_RST;
            dac_code_q <= 12'h000;
        end else if (wr_en) begin
            if (sec.addr == codec_pkg::REG_VC_HIGH) begin
                vc_high_q <= sec.data;
            end
            if (sec.addr == codec_pkg::REG_VC_LOW) begin
                vc_low_q <= sec.data;
                dac_code_q <= {vc_high_q, sec.data[3:0]};
            end
        end
    end

    assign vcxo_dac_code = dac_code_q;
    assign vcxo_dac_level = dac_code_q + codec_pkg::DAC_OFFSET;

    assign tx_lpf_125k = filter_q[codec_pkg::FMR_TX_LPF_BIT];
    assign rx_hpf_168k = filter_q[codec_pkg::FMR_RX_HPF_BIT];
    assign tx_hpf_bypass = mode_q[codec_pkg::MODE_HPF_BYPASS_BIT];
    assign driver_power_down = power_q[codec_pkg::PWR_DRIVER_BIT];
    assign tx_atten_db = atten_q;
    assign rx_fine_gain_db = fine_q;
    assign coarse_receive_gain = coarse_q;

    // auxiliary clock dividers
    logic [7:0] a1_cnt_q;
    logic [7:0] a2_cnt_q;
    logic a1_q;
    logic a2_q;
    logic [7:0] a1_half;
    assign a1_half = clock_q[codec_pkg::CLK1_SEL_BIT]
        ? 8'(codec_pkg::CLK1_SLOW_HALF) : 8'(codec_pkg::CLK1_FAST_HALF);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            a1_cnt_q <= 8'h00;
            a1_q <= 1'b0;
        end else if (!clock_q[codec_pkg::CLK1_EN_BIT]) begin
            a1_cnt_q <= 8'h00;
            a1_q <= 1'b0;
        end else if (a1_cnt_q >= a1_half - 8'h01) begin
            a1_cnt_q <= 8'h00;
            a1_q <= ~a1_q;
        end else begin
            a1_cnt_q <= a1_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            a2_cnt_q <= 8'h00;
            a2_q <= 1'b0;
        end else if (!clock_q[codec_pkg::CLK2_EN_BIT]) begin
            a2_cnt_q <= 8'h00;
            a2_q <= 1'b0;
        end else if (a2_cnt_q == 8'(codec_pkg::CLK2_HALF - 1)) begin
            a2_cnt_q <= 8'h00;
            a2_q <= ~a2_q;
        end else begin
            a2_cnt_q <= a2_cnt_q + 8'h01;
        end
    end

    assign aux_clock_one = a1_q;
    assign aux_clock_two = a2_q;
endmodule
`default_nettype wire

/* verification/codec_checker.sv */
// concurrent checks on the codec serial port pins
// assumes one sys_clk domain and reset active high
`timescale 1ns/1ps
`default_nettype none
module codec_checker (
    input wire logic sys_clk, // clock
    input wire logic reset, // reset
    input wire logic shift_clock, // shift clock
    input wire logic transmit_frame_sync, // out sync
    input wire logic receive_frame_sync, // in sync
    input wire logic reduced_rate, // rate mode
    input wire logic dac_valid, // sample pulse
    input wire logic [4:0] tx_atten_db, // attenuation
    input wire logic [3:0] rx_fine_gain_db, // fine gain
    input wire logic [11:0] vcxo_dac_code, // dac code
    input wire logic [11:0] vcxo_dac_level // dac level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_sclk_toggle: assert property (!$past(reset) |->
        shift_clock != $past(shift_clock))
        else $error("shift clock stalled");
    a_fsx_width: assert property ($rose(transmit_frame_sync) |=>
        transmit_frame_sync ##1 !transmit_frame_sync)
        else $error("out sync width wrong");
    a_fsr_width: assert property ($rose(receive_frame_sync) |=>
        receive_frame_sync ##1 !receive_frame_sync)
        else $error("in sync width wrong");
    a_sync_on_rise: assert property ($rose(receive_frame_sync) ||
        $rose(transmit_frame_sync) |-> $rose(shift_clock))
        else $error("sync not on shift rise");
    a_full_rate: assert property ($rose(transmit_frame_sync) &&
        !reduced_rate |-> ##32 (transmit_frame_sync || reduced_rate))
        else $error("full rate period wrong");
    a_reduced_rate: assert property ($rose(transmit_frame_sync) &&
        reduced_rate |-> ##64 (transmit_frame_sync || !reduced_rate))
        else $error("reduced rate period wrong");
    a_dac_pulse: assert property (dac_valid |->
        $past(receive_frame_sync, 32) ##1 !dac_valid)
        else $error("sample pulse misplaced");
    a_code_load: assert property ($changed(vcxo_dac_code) |->
        $past(receive_frame_sync, 32))
        else $error("dac code changed off a word");
    a_level_offset: assert property (vcxo_dac_level ==
        vcxo_dac_code + 12'h800)
        else $error("dac level offset wrong");
    a_atten_range: assert property (tx_atten_db <= 5'h18)
        else $error("attenuation above range");
    a_gain_range: assert property (rx_fine_gain_db <= 4'h9)
        else $error("fine gain above range");
endmodule
bind codec_serial_port codec_checker chk (.sys_clk, .reset, .shift_clock,
    .transmit_frame_sync, .receive_frame_sync, .reduced_rate, .dac_valid,
    .tx_atten_db, .rx_fine_gain_db, .vcxo_dac_code, .vcxo_dac_level);
`default_nettype wire

/* verification/host_dsp_model.sv */
// host serial port model: sends queued words, collects device words
// assumes shift clock and syncs synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module host_dsp_model (
    input wire logic sys_clk, // clock
    input wire logic shift_clock, // shift clock
    input wire logic transmit_frame_sync, // out sync
    input wire logic receive_frame_sync, // in sync
    input wire logic serial_out_line, // device data
    output logic serial_in_line // host data
);
    logic [15:0] q[$];
    logic [15:0] got[$];
    logic [15:0] sh;
    logic [15:0] rw;
    logic p = 1'b0;
    int n = 0;
    int m = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int nsync = 0;
    initial serial_in_line = 1'b0;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (shift_clock && receive_frame_sync) begin
            sh = (q.size() > 0) ? q.pop_front() : 16'h0000;
            serial_in_line <= sh[15];
            n <= 15;
            gap <= cyc - last;
            last <= cyc;
            nsync <= nsync + 1;
        end else if (shift_clock && n > 0) begin
            serial_in_line <= sh[n-1];
            n <= n - 1;
        end else if (shift_clock) begin
            serial_in_line <= ~serial_in_line;
        end
    end
    always @(posedge sys_clk) begin
        if (shift_clock && transmit_frame_sync) p <= 1'b1;
        if (!shift_clock) begin
            if (m > 0) rw = {rw[14:0], serial_out_line};
            if (m == 1) got.push_back(rw);
            m <= p ? 16 : (m > 0 ? m - 1 : 0);
            p <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the codec serial port
// assumes host model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk, reset, rate_mode_pin, adc_valid, adc_ready, r;
    logic shift_clock, transmit_frame_sync, receive_frame_sync;
    logic serial_out_line, serial_in_line, dac_valid, reduced_rate;
    logic tx_lpf_125k, rx_hpf_168k, tx_hpf_bypass, driver_power_down;
    logic aux_clock_one, aux_clock_two;
    logic [13:0] adc_sample, dac_sample;
    logic [4:0] tx_atten_db;
    logic [3:0] rx_fine_gain_db, coarse_receive_gain;
    logic [11:0] vcxo_dac_code, vcxo_dac_level;
    logic [15:0] exp_q[$];
    int n_fail = 0;
    int checks_done = 0;
    int nref = 0;
    int i;
    codec_serial_port dut (.*);
    host_dsp_model host (.sys_clk, .shift_clock, .transmit_frame_sync,
        .receive_frame_sync, .serial_out_line, .serial_in_line);
    task chk(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t ns: got %h want %h", $time, got, want);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // primary word with request, then the control word
    task wr(input logic [4:0] a, input logic [7:0] d, input logic bad);
        host.q.push_back(16'h1237);
        host.q.push_back({bad, a, 2'b00, d});
        while (host.q.size() > 0) step(1);
        step(2);
        chk(host.gap, 16'd96);
        chk(dac_sample, 14'h048D);
        while (host.n > 0) step(1);
        step(4);
    endtask
    task per(input logic [15:0] want);
        i = host.nsync + 2;
        while (host.nsync < i) step(1);
        chk(host.gap, want);
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        rate_mode_pin = 1'b0;
        adc_valid = 1'b0;
        adc_sample = 14'h2A00;
        step(16);
        reset <= 1'b0;
        step(4);
        r = aux_clock_two;
        step(1);
        chk(aux_clock_two, !r);
        host.got.delete();
        adc_valid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(negedge sys_clk) r = adc_ready;
            @(posedge sys_clk) if (r) begin
                exp_q.push_back({adc_sample, 2'b00});
                adc_sample <= adc_sample + 14'h0001;
            end else nref++;
        end
        adc_valid <= 1'b0;
        chk(nref != 0, 1'b1);
        step(700);
        while (host.got.size() > 0 && host.got[0] == 16'h0000)
            void'(host.got.pop_front());
        foreach (exp_q[k]) chk(host.got[k], exp_q[k]);
        rate_mode_pin <= 1'b1;
        step(2);
        chk(reduced_rate, 1'b1);
        per(16'd256);
        wr(5'h01, 8'h0E, 1'b0);
        chk({reduced_rate, tx_hpf_bypass}, 2'b01);
        per(16'd128);
        wr(5'h02, 8'h14, 1'b0);
        chk({tx_lpf_125k, rx_hpf_168k}, 2'b11);
        wr(5'h02, 8'h10, 1'b0);
        chk({tx_lpf_125k, rx_hpf_168k}, 2'b10);
        wr(5'h03, 8'h1F, 1'b0);
        wr(5'h03, 8'h05, 1'b1);
        wr(5'h1F, 8'h07, 1'b0);
        chk(tx_atten_db, 5'h18);
        wr(5'h04, 8'h3C, 1'b0);
        chk({coarse_receive_gain, rx_fine_gain_db}, 8'h39);
        wr(5'h05, 8'h01, 1'b0);
        chk(driver_power_down, 1'b1);
        wr(5'h07, 8'h80, 1'b0);
        chk(vcxo_dac_code, 12'h000);
        wr(5'h08, 8'hA5, 1'b0);
        chk(vcxo_dac_code, 12'h805);
        chk(vcxo_dac_level, 12'h005);
        wr(5'h06, 8'h01, 1'b0);
        chk({aux_clock_one, aux_clock_two}, 2'b00);
        step(1);
        chk({aux_clock_one, aux_clock_two}, 2'b00);
        test_done();
    end
endmodule
`default_nettype wire
